// ===== rtl/serial_port.sv
// Serial port with flags, requests, line control and 16x receiver
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"
module serial_port
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic sck,
  output req_s req,
  output logic [2:0] top_req
);

  state_s s;
  state_s n;
  logic tick;
  logic bit_end;
  logic rx_smp;
  logic sync;
  logic te;
  logic re;
  logic rxerr;
  logic can_load;
  logic load;
  logic fin;
  logic done;
  logic f_hit;
  logic p_hit;

  always_comb
  begin
    n = s;
    load = 1'b0;
    fin = 1'b0;
    done = 1'b0;
    f_hit = 1'b0;
    p_hit = 1'b0;
    // Shared bit-phase counter, one step per base-clock pulse
    tick = (s.div_cnt == s.baud);
    n.div_cnt = tick ? 8'h00 : s.div_cnt + 8'h01;
    n.ph = tick ? s.ph + 4'h1 : s.ph;
    bit_end = tick && (s.ph == `LAST_PH);
    sync = s.ctrl[`CTRL_SYNC];
    re = s.ctrl[`CTRL_RE];
    rxerr = s.overrun_flag | s.framing_error_flag | s.per;
    can_load = !s.tx_buffer_empty_flag && !(sync && rxerr); // [RULE17] [RULE22]
    n.rx_prev = rxd;

    // Software first, so that hardware sets below win over clears
    if (wr_en)
    begin
      case (addr)
        `OFS_CTRL: n.ctrl = wdata;
        `OFS_STAT:
        begin
          // Writing 0 clears a flag, writing 1 leaves it; the complete flag clears only with the empty flag
          if (!wdata[`STAT_TX_BUFFER_EMPTY_FLAG])
          begin
            n.tx_buffer_empty_flag = 1'b0;
            n.tx_complete_flag = 1'b0;
          end
          if (!wdata[`STAT_RX_BUFFER_FULL_FLAG])
            n.rx_buffer_full_flag = 1'b0;
          if (!wdata[`STAT_OVERRUN_FLAG])
            n.overrun_flag = 1'b0;
          if (!wdata[`STAT_FER])
            n.framing_error_flag = 1'b0;
          if (!wdata[`STAT_PER])
            n.per = 1'b0;
        end
        `OFS_TXH: n.txh = wdata; // [RULE9]
        `OFS_BAUD: n.baud = wdata;
        `OFS_PORT: n.port = {6'h00, wdata[1:0]};
        default: ;
      endcase
    end
    // Transmit enable acts in the cycle of its write
    te = n.ctrl[`CTRL_TE];

    if (!te)
    begin
      // Abandons any frame in flight, no matter where it stands
      n.tx = TX_IDLE; // [RULE16]
      n.tx_buffer_empty_flag = 1'b1;
      n.tx_complete_flag = 1'b1;
    end
    else
    begin
      unique case (s.tx)
        TX_IDLE:
          load = can_load && bit_end; // [RULE22]
        TX_START:
          if (bit_end)
            n.tx = TX_DATA;
        TX_DATA:
          if (bit_end)
          begin
            n.tx_par = s.tx_par ^ s.tx_shift_reg[s.tx_bit];
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == 3'h7)
            begin
              if (sync)
                fin = 1'b1;
              else if (s.ctrl[`CTRL_PAR])
                n.tx = TX_PAR;
              else
                n.tx = TX_STOP;
            end
          end
        TX_PAR:
          if (bit_end)
            n.tx = TX_STOP;
        TX_STOP:
          fin = bit_end;
      endcase
      if (fin)
      begin
        n.tx = TX_IDLE;
        n.tx_complete_flag = s.tx_buffer_empty_flag; // [RULE4]
        load = can_load;
      end
      if (load)
      begin
        n.tx_shift_reg = s.txh;
        n.tx_buffer_empty_flag = 1'b1; // [RULE8]
        n.tx_complete_flag = 1'b0;
        n.tx_bit = 3'h0;
        n.tx_par = 1'b0;
        n.tx = sync ? TX_DATA : TX_START;
      end
    end

    // Line level; sync idle holds the last bit sent
    unique case (n.tx)
      TX_IDLE: n.txd = sync ? s.txd : 1'b1;
      TX_START: n.txd = 1'b0;
      TX_DATA: n.txd = n.tx_shift_reg[n.tx_bit];
      TX_PAR: n.txd = n.tx_par;
      TX_STOP: n.txd = 1'b1;
    endcase
    // Port data stands in for mark, which lets software send a break
    if (!te)
      n.txd = n.port[`PORT_DATA]; // [RULE14] [RULE15] [RULE16]
    n.txd_oe = te | n.port[`PORT_DIR]; // [RULE14]

    // Receiver phase restarts at each start edge, 16 pulses per bit
    n.rx_ph = tick ? s.rx_ph + 4'h1 : s.rx_ph;
    if (sync)
      rx_smp = tick && (s.ph == `SAMPLE_PH);
    else
      rx_smp = tick && (s.rx_ph == `SAMPLE_PH); // [RULE20]

    if (!re)
      n.rx = RX_IDLE; // [RULE18]
    else
    begin
      unique case (s.rx)
        RX_IDLE:
          if (sync)
          begin
            if (bit_end && !rxerr)
            begin
              n.rx = RX_DATA;
              n.rx_bit = 3'h0;
            end
          end
          else if (s.rx_prev && !rxd)
          begin
            n.rx = RX_START; // [RULE19]
            n.rx_ph = 4'h0;
          end
        RX_START:
          if (rx_smp)
          begin
            // A start bit gone high by mid-bit was a glitch
            n.rx = rxd ? RX_IDLE : RX_DATA;
            n.rx_bit = 3'h0;
            n.rx_par = 1'b0;
            n.rx_pe = 1'b0;
          end
        RX_DATA:
          if (rx_smp)
          begin
            n.rx_shift_reg[s.rx_bit] = rxd;
            n.rx_par = s.rx_par ^ rxd;
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7)
            begin
              if (sync)
              begin
                done = 1'b1;
                n.rx = RX_IDLE;
              end
              else if (s.ctrl[`CTRL_PAR])
                n.rx = RX_PAR;
              else
                n.rx = RX_STOP;
            end
          end
        RX_PAR:
          if (rx_smp)
          begin
            n.rx_pe = s.rx_par ^ rxd;
            n.rx = RX_STOP;
          end
        RX_STOP:
          if (rx_smp)
          begin
            done = 1'b1;
            f_hit = !rxd; // [RULE12]
            p_hit = s.rx_pe;
            // A line still low starts the next frame with no edge
            n.rx = rxd ? RX_IDLE : RX_START; // [RULE13]
          end
      endcase
    end

    if (done)
    begin
      if (n.rx_buffer_full_flag)
        n.overrun_flag = 1'b1; // [RULE10]
      else
      begin
        n.rxh = n.rx_shift_reg; // [RULE11]
        if (!f_hit && !p_hit)
          n.rx_buffer_full_flag = 1'b1;
      end
      if (f_hit)
        n.framing_error_flag = 1'b1; // [RULE11] [RULE12]
      if (p_hit)
        n.per = 1'b1;
    end

    // Clock low for the first half of each bit, so data moves on falls
    n.sck = !(sync && (n.tx == TX_DATA || n.rx == RX_DATA)) || n.ph[3];

    // Levels, held while flag and enable both stand
    n.req.err = (n.overrun_flag | n.framing_error_flag | n.per)
                & n.ctrl[`CTRL_RIE]; // [RULE6] [RULE23] [RULE24]
    n.req.full = n.rx_buffer_full_flag & n.ctrl[`CTRL_RIE]; // [RULE2] [RULE5]
    n.req.empty = n.tx_buffer_empty_flag & n.ctrl[`CTRL_TIE]; // [RULE2] [RULE3]
    n.req.fin = n.tx_complete_flag & n.ctrl[`CTRL_TRANSMIT_END_IRQ_ENABLE]; // [RULE2] [RULE4]
    if (n.req.err)
      n.top = {1'b1, `CODE_ERR}; // [RULE7]
    else if (n.req.full)
      n.top = {1'b1, `CODE_FULL};
    else if (n.req.empty)
      n.top = {1'b1, `CODE_EMPTY};
    else if (n.req.fin)
      n.top = {1'b1, `CODE_END};
    else
      n.top = 3'h0;

    n.rdata = 8'h00;
    if (rd_en)
    begin
      case (addr)
        `OFS_CTRL: n.rdata = s.ctrl;
        `OFS_STAT: n.rdata = {2'h0, s.tx_complete_flag, s.per, s.framing_error_flag, s.overrun_flag,
                              s.rx_buffer_full_flag, s.tx_buffer_empty_flag};
        `OFS_TXH: n.rdata = s.txh;
        `OFS_RXH: n.rdata = s.rxh;
        `OFS_BAUD: n.rdata = s.baud;
        `OFS_PORT: n.rdata = {5'h00, rxd, s.port[1:0]};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.tx <= TX_IDLE;
      s.rx <= RX_IDLE;
      s.tx_buffer_empty_flag <= 1'b1;
      s.tx_complete_flag <= 1'b1;
      s.baud <= `BAUD_RST;
      s.port <= `PORT_RST;
      s.rx_prev <= 1'b1;
      s.sck <= 1'b1;
    end
    else
      s <= n;
  end

  // Each request is its own wire to the interrupt controller
  assign req = s.req; // [RULE1]
  assign top_req = s.top;
  assign rdata = s.rdata;
  assign txd = s.txd;
  assign txd_oe = s.txd_oe;
  assign sck = s.sck;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_fall;
    s.rx == RX_IDLE && re && !sync && s.rx_prev && !rxd;
  endsequence

  sequence s_load;
    te && s.tx == TX_IDLE && can_load && bit_end;
  endsequence

  sequence s_mid_start;
    s.rx == RX_START && re && !rxd && tick && s.rx_ph == `SAMPLE_PH;
  endsequence

  sequence s_stop_low;
    s.rx == RX_STOP && re && rx_smp && !rxd;
  endsequence

  a_err_request: assert property ( // [RULE6] [RULE23]
    req.err == ((s.overrun_flag | s.framing_error_flag | s.per) && s.ctrl[`CTRL_RIE]))
    else $error("error request does not follow flags");
  a_full_request: assert property ( // [RULE5]
    req.full == (s.rx_buffer_full_flag && s.ctrl[`CTRL_RIE]))
    else $error("full request does not follow flag");
  a_empty_request: assert property ( // [RULE3]
    $rose(s.tx_buffer_empty_flag) && s.ctrl[`CTRL_TIE] |-> req.empty)
    else $error("empty request missing");
  a_end_request: assert property ( // [RULE4] [RULE24]
    req.fin == (s.tx_complete_flag && s.ctrl[`CTRL_TRANSMIT_END_IRQ_ENABLE]))
    else $error("end request does not follow flag");
  a_empty_level: assert property ( // [RULE2] [RULE24]
    req.empty == (s.tx_buffer_empty_flag && s.ctrl[`CTRL_TIE]))
    else $error("empty request does not follow flag");
  a_request_priority: assert property ( // [RULE7]
    req.err |-> top_req == {1'b1, `CODE_ERR})
    else $error("error request not on top");
  a_full_over_empty: assert property ( // [RULE7]
    !req.err && req.full |-> top_req == {1'b1, `CODE_FULL})
    else $error("full request not ranked second");
  a_empty_over_end: assert property ( // [RULE7]
    !req.err && !req.full && req.empty |-> top_req == {1'b1, `CODE_EMPTY})
    else $error("empty request not ranked third");
  a_end_lowest: assert property ( // [RULE7]
    req == 4'h1 |-> top_req == {1'b1, `CODE_END})
    else $error("end request not ranked last");
  a_no_request: assert property ( // [RULE1] [RULE7]
    req == 4'h0 |-> top_req == 3'h0)
    else $error("top request shown with none pending");
  a_load_sets_empty: assert property ( // [RULE8] [RULE22]
    s_load |=> s.tx_buffer_empty_flag && s.tx_shift_reg == $past(s.txh))
    else $error("holding byte not loaded");
  a_no_load_full: assert property ( // [RULE22]
    te && s.tx == TX_IDLE && s.tx_buffer_empty_flag |=> s.tx == TX_IDLE)
    else $error("transmit started without new data");
  a_overrun_drops: assert property ( // [RULE10]
    $rose(s.overrun_flag) |-> s.rx_buffer_full_flag && $stable(s.rxh))
    else $error("overrun moved data or lost full flag");
  a_error_stores: assert property ( // [RULE11] [RULE12]
    s_stop_low ##0 !s.rx_buffer_full_flag |=> s.framing_error_flag && !s.rx_buffer_full_flag && s.rxh == $past(s.rx_shift_reg))
    else $error("framing error did not store the byte");
  a_break_repeats: assert property ( // [RULE13]
    s_stop_low |=> s.rx == RX_START)
    else $error("receiver stopped during break");
  a_port_fallback: assert property ( // [RULE14] [RULE15]
    !s.ctrl[`CTRL_TE] |-> txd == s.port[`PORT_DATA]
      && txd_oe == s.port[`PORT_DIR])
    else $error("pin does not follow port bits");
  a_pin_driven: assert property ( // [RULE14]
    s.ctrl[`CTRL_TE] |-> txd_oe)
    else $error("pin not driven while transmitting");
  a_te_clear_init: assert property ( // [RULE16]
    $fell(s.ctrl[`CTRL_TE]) |-> s.tx_buffer_empty_flag && s.tx_complete_flag && s.tx == TX_IDLE)
    else $error("transmitter not reset");
  a_sync_tx_block: assert property ( // [RULE17]
    te && sync && rxerr && s.tx == TX_IDLE ##1 te |-> s.tx == TX_IDLE)
    else $error("sync transmit started with error");
  a_re_keeps_flags: assert property ( // [RULE18]
    $fell(s.ctrl[`CTRL_RE]) |-> (s.overrun_flag || !$past(s.overrun_flag))
      && (s.framing_error_flag || !$past(s.framing_error_flag)) && (s.per || !$past(s.per)))
    else $error("receive disable changed error flags");
  a_start_align: assert property ( // [RULE19]
    s_fall |=> s.rx == RX_START && s.rx_ph == 4'h0)
    else $error("start edge not aligned");
  a_mid_sample: assert property ( // [RULE20]
    s_mid_start |=> s.rx == RX_DATA && s.rx_bit == 3'h0)
    else $error("start bit not taken at mid-bit");
endmodule // serial_port
`default_nettype wire

// ===== rtl/serial_port_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
// How it works
// [RULE1] Four request outputs, each on its own line.
// [RULE2] Empty and full requests use own enables; end request uses its own.
// [RULE3] Empty request follows empty flag while transmit irq enable is set.
// [RULE4] End request follows complete flag while end enable is set.
// [RULE5] Full request follows full flag while receive irq enable is set.
// [RULE6] Error request on overrun, parity or framing flag, gated by enable.
// [RULE7] Fixed priority: error, full, empty, end.
// [RULE8] Empty flag sets when holding byte moves into shift register.
// [RULE9] Holding writes always accepted; software checks empty flag first.
// [RULE10] Overrun sets overrun flag, keeps full flag, drops received byte.
// [RULE11] Framing or parity error alone still stores byte; full stays 0.
// [RULE12] A break sets the framing flag, maybe the parity flag.
// [RULE13] Receiver keeps running in a break, so framing flag sets again.
// [RULE14] With transmit off the pin is a port pin from data and direction.
// [RULE15] Port data replaces idle mark level until transmit is enabled.
// [RULE16] Clearing transmit enable resets the transmitter at once.
// [RULE17] Synchronous mode: no transmit start while a receive error stands.
// [RULE18] Clearing receive enable leaves the error flags untouched.
// [RULE19] Async receive runs at 16x and aligns to start bit falling edge.
// [RULE20] Each async bit latched on eighth base-clock pulse, mid-bit.
// [RULE21] External sync clock waits 5 cycles after holding reset. Not done: sck only comes from the internal phase counter.
// [RULE22] Software clearing empty flag makes the holding byte load.
// [RULE23] Error request shares the receive interrupt enable.
// [RULE24] Requests are levels while flag and enable both stand.
`define OFS_CTRL 3'h0
`define OFS_STAT 3'h1
`define OFS_TXH 3'h2
`define OFS_RXH 3'h3
`define OFS_BAUD 3'h4
`define OFS_PORT 3'h5
`define CTRL_TIE 0
`define CTRL_RIE 1
`define CTRL_TE 2
`define CTRL_RE 3
`define CTRL_TRANSMIT_END_IRQ_ENABLE 4
`define CTRL_SYNC 5
`define CTRL_PAR 6
`define STAT_TX_BUFFER_EMPTY_FLAG 0
`define STAT_RX_BUFFER_FULL_FLAG 1
`define STAT_OVERRUN_FLAG 2
`define STAT_FER 3
`define STAT_PER 4
`define STAT_TX_COMPLETE_FLAG 5
`define PORT_DATA 0
`define PORT_DIR 1
`define PORT_PIN 2
`define BAUD_RST 8'h00
`define PORT_RST 8'h00
`define SAMPLE_PH 4'h7
`define LAST_PH 4'hf
`define EXT_CLK_WAIT_CYC 5
`define CODE_ERR 2'h0
`define CODE_FULL 2'h1
`define CODE_EMPTY 2'h2
`define CODE_END 2'h3
`endif

// ===== rtl/serial_port_pkg.sv
// Types shared by the serial port design
package serial_port_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
    TX_PAR = 5'h08, TX_STOP = 5'h10
  } tx_state_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_e;
  typedef struct packed {
    logic err;
    logic full;
    logic empty;
    logic fin;
  } req_s;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] port;
    logic [7:0] baud;
    logic tx_buffer_empty_flag, rx_buffer_full_flag, overrun_flag, framing_error_flag, per, tx_complete_flag;
    logic [7:0] txh, tx_shift_reg, rxh, rx_shift_reg;
    logic [7:0] div_cnt;
    logic [3:0] ph;
    tx_state_e tx;
    logic [2:0] tx_bit;
    logic tx_par;
    rx_state_e rx;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic rx_par, rx_pe, rx_prev;
    logic txd, txd_oe, sck;
    logic [7:0] rdata;
    req_s req;
    logic [2:0] top;
  } state_s;
endpackage

// ===== verification/serial_node.sv
// Remote serial node: drives the receive pin and decodes the transmit pin
`timescale 1ns/1ps
`default_nettype none
module serial_node
(
  input wire logic clk,
  input wire logic txd,
  output logic line
);
  // Idle is the mark level, as the pulled-up line rests
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] fr;
    int i;
    fr = {stp, d, 1'b0};
    for (i = 0; i < 10; i++)
    begin
      line <= fr[i];
      repeat (16) @(posedge clk);
    end
    line <= 1'b1;
  endtask
  task automatic brk(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
  endtask
  // Samples at mid-bit; a bounded wait so a dead transmitter cannot hang
  task automatic get(output logic [7:0] d);
    int i;
    i = 0;
    while (txd !== 1'b0 && i < 300)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    repeat (8) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge clk);
      d[i] = txd;
    end
  endtask
endmodule // serial_node
`default_nettype wire

// ===== verification/serial_port_tb.sv
// Self-checking bench for the serial port flags, requests and pins
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
  logic clk, resetn, wr_en, rd_en, rxd, txd, txd_oe, sck;
  logic [2:0] addr, top_req;
  logic [7:0] wdata, rdata, d, lo;
  logic [3:0] req;
  int n_fail, checks_done, cyc, i;
  serial_port serial_port_i (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd),
    .txd(txd), .txd_oe(txd_oe), .sck(sck), .req(req), .top_req(top_req));
  serial_node serial_node_i (.clk(clk), .txd(txd), .line(rxd));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk($sformatf("reg %0d", a), e, rdata);
  endtask
  // Requests are levels, so a short settle before looking is harmless
  task automatic rq(input logic [3:0] r, input logic [2:0] t);
    tk(2);
    chk("req", {4'h0, r}, {4'h0, req});
    chk("top_req", {5'h0, t}, {5'h0, top_req});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rc(1, 8'h21);
    rc(0, 8'h00);
    rc(5, 8'h04);
    wr(7, 8'hff);
    rc(7, 8'h00);
    rc(6, 8'h00);
    wr(0, 8'h15);
    rq(4'h3, 3'h6);
    wr(0, 8'h04);
    rq(4'h0, 3'h0);
    wr(0, 8'h15);
    rc(1, 8'h21);
    wr(2, 8'ha5);
    wr(1, 8'h00);
    serial_node_i.get(d);
    chk("tx byte", 8'ha5, d);
    rc(1, 8'h01);
    tk(40);
    rc(1, 8'h21);
    rq(4'h3, 3'h6);
    wr(0, 8'h0a);
    serial_node_i.send(8'h3c, 1'b1);
    rq(4'h4, 3'h5);
    rc(3, 8'h3c);
    serial_node_i.send(8'hc3, 1'b1);
    tk(4);
    rc(1, 8'h27);
    rc(3, 8'h3c);
    rq(4'hc, 3'h4);
    wr(1, 8'h21);
    serial_node_i.send(8'h99, 1'b0);
    tk(4);
    rc(1, 8'h29);
    rc(3, 8'h99);
    rq(4'h8, 3'h4);
    wr(1, 8'h21);
    wr(0, 8'h4a);
    serial_node_i.send(8'h3c, 1'b1);
    tk(20);
    rc(1, 8'h31);
    rc(3, 8'h3c);
    wr(0, 8'h0a);
    tk(160);
    wr(1, 8'h21);
    fork
      serial_node_i.brk(600);
      begin
        tk(200);
        rc(1, 8'h29);
        wr(1, 8'h21);
        tk(200);
        rc(1, 8'h29);
        wr(0, 8'h02);
      end
    join
    tk(20);
    rc(1, 8'h29);
    rq(4'h8, 3'h4);
    wr(0, 8'h00);
    rq(4'h0, 3'h0);
    wr(2, 8'h5a);
    wr(0, 8'h24);
    wr(1, 8'h28);
    lo = 8'h00;
    for (i = 0; i < 100; i++)
    begin
      tk(1);
      lo = lo + {7'h0, sck !== 1'b1};
    end
    chk("sck low cycles", 8'h00, lo);
    wr(2, 8'hc3);
    rc(2, 8'hc3);
    tk(5);
    wr(1, 8'h21);
    lo = 8'h00;
    for (i = 0; i < 200; i++)
    begin
      tk(1);
      lo = lo + {7'h0, sck !== 1'b1};
    end
    chk("sync clock lows", 8'h40, lo);
    rc(1, 8'h21);
    wr(0, 8'h00);
    wr(1, 8'h21);
    wr(5, 8'h03);
    tk(2);
    chk("idle port pin", 8'h03, {6'h0, txd_oe, txd});
    rc(5, 8'h07);
    wr(5, 8'h01);
    tk(2);
    chk("port input", 8'h00, {7'h0, txd_oe});
    wr(5, 8'h03);
    wr(0, 8'h04);
    wr(2, 8'hff);
    wr(1, 8'h20);
    tk(40);
    wr(5, 8'h02);
    wr(0, 8'h00);
    lo = 8'h00;
    for (i = 0; i < 40; i++)
    begin
      tk(1);
      lo = lo + {7'h0, txd !== 1'b0 || txd_oe !== 1'b1};
    end
    chk("break cycles", 8'h00, lo);
    rc(1, 8'h21);
    conclude();
  end
endmodule // serial_port_tb
`default_nettype wire
